/* File: rtl/rtc_range_fix_and_trim.sv */
`timescale 1ns/1ps
module rtc_range_fix_and_trim #(
  parameter int SEC_TICKS = rtc_trim_pkg::OSC_HZ  // oscillator ticks per second
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // events
  output logic             ONE_SEC_O,
  output logic             IRQ_O
);
  localparam logic [15:0] SEC_TERM = 16'(SEC_TICKS - 1);  // untrimmed terminal count
  localparam logic [10:0] OSC_TERM = 11'(rtc_trim_pkg::OSC_DIV_CYC - 1);
  rtc_trim_pkg::tod_type tod_reg, tod_next;  // time-of-day counters
  logic [31:0] ctrl_reg;                     // run, mode, alarm enable, trim
  logic [31:0] alarm_reg;                    // alarm minute and hour
  logic [1:0]  stat_reg, stat_next;          // sticky events
  logic [1:0]  mask_reg;                     // interrupt mask
  logic [10:0] osc_cnt_reg;                  // prescaler to oscillator rate
  logic [15:0] div_cnt_reg;                  // oscillator divider chain
  logic [15:0] term_reg;                     // terminal count this second
  logic        trim_pend_reg;                // trim waiting for next interval
  logic        one_sec_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        irq_reg;
  // apb decode
  wire         setup    = PSEL_I & ~PENABLE_I;
  wire         wr_acc   = PSEL_I & PENABLE_I & pready_reg & PWRITE_I;
  wire         hit_ctrl = PADDR_I == rtc_trim_pkg::OFF_CTRL;
  wire         hit_time = PADDR_I == rtc_trim_pkg::OFF_TIME;
  wire         hit_date = PADDR_I == rtc_trim_pkg::OFF_DATE;
  wire         hit_alm  = PADDR_I == rtc_trim_pkg::OFF_ALARM;
  wire         hit_stat = PADDR_I == rtc_trim_pkg::OFF_STAT;
  wire         hit_mask = PADDR_I == rtc_trim_pkg::OFF_MASK;
  wire         mapped   = hit_ctrl | hit_time | hit_date | hit_alm | hit_stat | hit_mask;
  wire         trim_wr  = wr_acc & hit_ctrl;
  wire         wr_time  = wr_acc & hit_time;
  wire         wr_date  = wr_acc & hit_date;
  // control fields
  wire         run      = ctrl_reg[rtc_trim_pkg::CTL_RUN];
  wire         h24      = ctrl_reg[rtc_trim_pkg::CTL_H24];
  wire         alm_en   = ctrl_reg[rtc_trim_pkg::CTL_ALMEN];
  wire [6:0]   trim     = ctrl_reg[rtc_trim_pkg::CTL_TRIM +: rtc_trim_pkg::TRIM_W];
  // signed view of trim, sign extended to the divider width
  wire [15:0]  trim_ext = 16'($signed(trim));
  // divider chain timing
  wire         osc_en   = osc_cnt_reg == OSC_TERM;
  wire         sec_tick = osc_en & (div_cnt_reg >= term_reg);
  wire         half_sec = osc_en & (div_cnt_reg == (term_reg >> 1));
  // read data selection
  rtc_trim_pkg::tod_type t;
  assign t = tod_reg;
  wire [31:0]  time_word = (32'(t.sec) << rtc_trim_pkg::F_SEC)
                         | (32'(t.min) << rtc_trim_pkg::F_MIN)
                         | (32'(t.hour) << rtc_trim_pkg::F_HR)
                         | (32'(t.pm) << rtc_trim_pkg::F_PM);
  wire [31:0]  date_word = (32'(t.day) << rtc_trim_pkg::F_DAY)
                         | (32'(t.mon_u) << rtc_trim_pkg::F_MOU)
                         | (32'(t.mon_t) << rtc_trim_pkg::F_MOT)
                         | (32'(t.wday) << rtc_trim_pkg::F_WDY)
                         | (32'(t.year) << rtc_trim_pkg::F_YR);
  wire [31:0]  rd_word = hit_ctrl ? ctrl_reg :
                         hit_time ? time_word :
                         hit_date ? date_word :
                         hit_alm  ? alarm_reg :
                         hit_stat ? 32'(stat_reg) :
                         hit_mask ? 32'(mask_reg) : 32'h0000_0000;
  // days in the current month, leap every fourth year
  function automatic logic [4:0] days_in(input logic [4:0] mon, input logic [6:0] yr);
    logic [4:0] d;
    d = 5'h1F;
    if (mon == 5'(rtc_trim_pkg::FEB))
      d = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
    else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h0B)
      d = 5'h1E;
    return d;
  endfunction : days_in
  // count-up events and range checks
  logic        min_evt, hr_evt, day_evt, mon_evt, yr_evt;
  wire [4:0]   mon_bin = t.mon_t ? 5'(t.mon_u) + 5'h0A : 5'(t.mon_u);
  wire [4:0]   dim     = days_in(mon_bin, t.year);
  // tens 0 with units 0 is never written by software; treated as out of range
  wire         mon_ok  = t.mon_t ? (t.mon_u <= rtc_trim_pkg::MO_TMAX)
                                 : (t.mon_u != 4'h0 && t.mon_u <= rtc_trim_pkg::MO_UMAX);
  wire [31:0]  wd      = PWDATA_I;
  // counter chain next state
  always_comb
  begin
    tod_next = tod_reg;
    min_evt  = 1'b0;
    hr_evt   = 1'b0;
    day_evt  = 1'b0;
    mon_evt  = 1'b0;
    yr_evt   = 1'b0;
    if (sec_tick && run)
    begin
      // seconds
      if (t.sec >= rtc_trim_pkg::SEC_MAX)
      begin
        tod_next.sec = 6'h00;
        min_evt      = 1'b1;
      end
      else
        tod_next.sec = t.sec + 6'h01;
      // minutes
      if (min_evt)
      begin
        if (t.min >= rtc_trim_pkg::SEC_MAX)
        begin
          tod_next.min = 6'h00;
          hr_evt       = 1'b1;
        end
        else
          tod_next.min = t.min + 6'h01;
      end
      // hours, 24h mode
      if (hr_evt && h24)
      begin
        if (t.hour > rtc_trim_pkg::HR24_MAX)
          tod_next.hour = 5'h00;
        else if (t.hour == rtc_trim_pkg::HR24_MAX)
        begin
          tod_next.hour = 5'h00;
          day_evt       = 1'b1;
        end
        else
          tod_next.hour = t.hour + 5'h01;
      end
      // hours, 12h mode
      else if (hr_evt)
      begin
        if (t.hour == 5'h00 || t.hour > rtc_trim_pkg::HR12_MAX)
          tod_next.hour = 5'h01;
        else if (t.hour == rtc_trim_pkg::HR12_PRE)
        begin
          tod_next.hour = rtc_trim_pkg::HR12_MAX;
          tod_next.pm   = ~t.pm;
          day_evt       = t.pm;
        end
        else if (t.hour == rtc_trim_pkg::HR12_MAX)
          tod_next.hour = 5'h01;
        else
          tod_next.hour = t.hour + 5'h01;
      end
      // day and weekday
      if (day_evt)
      begin
        if (t.day == 5'h00 || t.day > dim)
          tod_next.day = 5'h01;
        else if (t.day == dim)
        begin
          tod_next.day = 5'h01;
          mon_evt      = 1'b1;
        end
        else
          tod_next.day = t.day + 5'h01;
        if (t.wday >= rtc_trim_pkg::WDY_MAX)
          tod_next.wday = 3'h0;
        else
          tod_next.wday = t.wday + 3'h1;
      end
      // month in tens bit and units field
      if (mon_evt)
      begin
        if (!mon_ok || (t.mon_t && t.mon_u == rtc_trim_pkg::MO_TMAX))
        begin
          tod_next.mon_t = 1'b0;
          tod_next.mon_u = 4'h1;
          yr_evt         = mon_ok;
        end
        else if (t.mon_u == rtc_trim_pkg::MO_UMAX)
        begin
          tod_next.mon_t = 1'b1;
          tod_next.mon_u = 4'h0;
        end
        else
          tod_next.mon_u = t.mon_u + 4'h1;
      end
      // year
      if (yr_evt)
        tod_next.year = (t.year >= rtc_trim_pkg::YEAR_MAX) ? 7'h00 : t.year + 7'h01;
    end
    // software loads win over counting
    if (wr_time)
    begin
      tod_next.sec  = wd[rtc_trim_pkg::F_SEC +: 6];
      tod_next.min  = wd[rtc_trim_pkg::F_MIN +: 6];
      tod_next.hour = wd[rtc_trim_pkg::F_HR +: 5];
      tod_next.pm   = wd[rtc_trim_pkg::F_PM];
    end
    if (wr_date)
    begin
      tod_next.day   = wd[rtc_trim_pkg::F_DAY +: 5];
      tod_next.mon_u = wd[rtc_trim_pkg::F_MOU +: 4];
      tod_next.mon_t = wd[rtc_trim_pkg::F_MOT];
      tod_next.wday  = wd[rtc_trim_pkg::F_WDY +: 3];
      tod_next.year  = wd[rtc_trim_pkg::F_YR +: 7];
    end
  end
  // events: second tick, alarm on minute and hour match at second zero
  wire         alm_hit = sec_tick & run & alm_en & min_evt
                       & (tod_next.min == alarm_reg[rtc_trim_pkg::F_MIN +: 6])
                       & (tod_next.hour == alarm_reg[rtc_trim_pkg::F_HR +: 5]);
  wire [1:0]   ev      = {alm_hit, sec_tick};
  wire [1:0]   w1c     = (wr_acc & hit_stat) ? wd[rtc_trim_pkg::ST_W-1:0] : 2'h0;
  assign stat_next = (stat_reg & ~w1c) | ev;  // set wins over clear
  // prescaler and divider chain
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      osc_cnt_reg <= 11'h000;
      div_cnt_reg <= 16'h0000;
    end
    else
    begin
      osc_cnt_reg <= osc_en ? 11'h000 : osc_cnt_reg + 11'h001;
      if (osc_en)
        div_cnt_reg <= sec_tick ? 16'h0000 : div_cnt_reg + 16'h0001;
    end
  end
  // one trimmed interval per trim write
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      term_reg      <= SEC_TERM;
      trim_pend_reg <= 1'b0;
    end
    else
    begin
      if (sec_tick)
        term_reg <= trim_pend_reg ? SEC_TERM - trim_ext : SEC_TERM;
      // a new write in the tick cycle stays pending
      if (trim_wr)
        trim_pend_reg <= 1'b1;
      else if (sec_tick)
        trim_pend_reg <= 1'b0;
    end
  end
  // one-second signal: high for the first half of each second
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      one_sec_reg <= 1'b0;
    else if (sec_tick)
      one_sec_reg <= 1'b1;
    else if (half_sec)
      one_sec_reg <= 1'b0;
  end
  // registers written by software
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      tod_reg   <= '0;
      ctrl_reg  <= rtc_trim_pkg::CTRL_RST;
      alarm_reg <= 32'h0000_0000;
      mask_reg  <= 2'h0;
      stat_reg  <= 2'h0;
      irq_reg   <= 1'b0;
    end
    else
    begin
      tod_reg  <= tod_next;
      stat_reg <= stat_next;
      irq_reg  <= |(stat_next & mask_reg);
      if (trim_wr)
        ctrl_reg <= wd & 32'h0000_7F07;
      if (wr_acc && hit_alm)
        alarm_reg <= wd & 32'h001F_3F00;
      if (wr_acc && hit_mask)
        mask_reg <= wd[rtc_trim_pkg::ST_W-1:0];
    end
  end
  // apb answer: one wait-free access phase
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup && !PWRITE_I)
        prdata_reg <= rd_word;
    end
  end

  assign PRDATA_O  = prdata_reg;
  assign PREADY_O  = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign ONE_SEC_O = one_sec_reg;
  assign IRQ_O     = irq_reg;

  // checks
  sequence trim_applied;
    sec_tick && trim_pend_reg && !trim_wr;
  endsequence
  sequence next_tick_plain;
    sec_tick && !trim_pend_reg;
  endsequence

  a_year_clear: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (yr_evt && t.year > rtc_trim_pkg::YEAR_MAX && !wr_date) |=> tod_reg.year == 7'h00)
    else $error("out of range year not cleared");
  a_month_load: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (mon_evt && !mon_ok && !wr_date) |=> (tod_reg.mon_u == 4'h1 && !tod_reg.mon_t))
    else $error("out of range month not loaded with one");
  a_trim_signed: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (sec_tick && trim_pend_reg) |=>
      ($signed(term_reg) == $signed(SEC_TERM) - $signed($past(trim))))
    else $error("trim not applied as signed value");
  a_one_sec_edge: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    $rose(one_sec_reg) |-> $past(sec_tick))
    else $error("one second signal rose off the tick");
  a_trim_once: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    trim_applied |=> !trim_pend_reg)
    else $error("trim still pending after its interval");
  a_trim_plain: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    next_tick_plain |=> term_reg == SEC_TERM)
    else $error("untrimmed interval not restored");
endmodule : rtc_range_fix_and_trim

/* File: rtl/rtc_trim_pkg.sv */
// Behaviour
// - bad year, weekday, 24h hour clear to 0
// - bad month, day, 12h hour load 1
// - trim is 7-bit signed, -64 to +63
// - observable one-second signal is provided
package rtc_trim_pkg;
  // system clock and nominal oscillator
  localparam int CLK_HZ      = 40_000_000;
  localparam int OSC_HZ      = 32768;
  localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;  // cycles per oscillator tick
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;  // clock_control_register
  localparam logic [7:0] OFF_TIME  = 8'h04;
  localparam logic [7:0] OFF_DATE  = 8'h08;  // holds month_register fields
  localparam logic [7:0] OFF_ALARM = 8'h0C;
  localparam logic [7:0] OFF_STAT  = 8'h10;
  localparam logic [7:0] OFF_MASK  = 8'h14;
  // control fields
  localparam int CTL_RUN   = 0;
  localparam int CTL_H24   = 1;  // twenty_four_hour_mode when set
  localparam int CTL_ALMEN = 2;
  localparam int CTL_TRIM  = 8;  // trim_correction_field lsb
  localparam int TRIM_W    = 7;
  // time and date fields
  localparam int F_SEC = 0;
  localparam int F_MIN = 8;
  localparam int F_HR  = 16;
  localparam int F_PM  = 21;
  localparam int F_DAY = 0;
  localparam int F_MOU = 8;   // month_units_field
  localparam int F_MOT = 12;  // month_tens_bit
  localparam int F_WDY = 16;
  localparam int F_YR  = 24;
  // status and mask bits
  localparam int ST_SEC = 0;
  localparam int ST_ALM = 1;
  localparam int ST_W   = 2;
  // counter limits
  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [4:0] HR24_MAX = 5'h17;
  localparam logic [4:0] HR12_MAX = 5'h0C;
  localparam logic [4:0] HR12_PRE = 5'h0B;
  localparam logic [2:0] WDY_MAX  = 3'h6;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [3:0] MO_UMAX  = 4'h9;
  localparam logic [3:0] MO_TMAX  = 4'h2;
  localparam logic [3:0] FEB      = 4'h2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  // time-of-day state carried as one word
  typedef struct packed {
    logic [6:0] year;
    logic [2:0] wday;
    logic       mon_t;
    logic [3:0] mon_u;
    logic [4:0] day;
    logic       pm;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tod_type;
endpackage : rtc_trim_pkg

/* File: sim/rtc_range_fix_and_trim_test.sv */
`timescale 1ns/1ps
module rtc_range_fix_and_trim_test;
  // shortened second keeps the run brief
  localparam int TICKS = 7;
  localparam int OSC   = rtc_trim_pkg::OSC_DIV_CYC;
  localparam int LIMIT = 3 * TICKS * OSC;
  // one expected read result
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } note_type;
  // bench drive and observe
  logic        mclk    = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] PRDATA_O;
  logic        PREADY_O;
  logic        PSLVERR_O;
  logic        ONE_SEC_O;
  logic        IRQ_O;
  note_type    notes[$];     // pending read expectations
  int          errors    = 0;
  int          cmp_count = 0;
  int          cyc       = 0; // free cycle count
  int          seed      = 32'hFB2D;
  logic [31:0] rnd;
  // device under test
  rtc_range_fix_and_trim #(.SEC_TICKS(TICKS)) dut (
    .MCLK_I(mclk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ONE_SEC_O(ONE_SEC_O), .IRQ_O(IRQ_O));
  // 40 mhz clock and cycle count
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // verdict and end of run
  task automatic print_verdict();
    // an expected answer that never came counts as a mismatch
    if (notes.size() != 0)
      errors++;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // plain value compare
  task automatic cmp_val(input logic [31:0] act, input logic [31:0] exp);
    cmp_count++;
    if (act !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : cmp_val
  // read result compare, oldest note first
  task automatic cmp_rd();
    note_type n;
    n = '{32'h0000_0000, 32'hFFFF_FFFF, 1'b1};  // unexpected answer
    if (notes.size() > 0)
      n = notes.pop_front();
    else
      errors++;
    cmp_val(PRDATA_O & n.mask, n.data & n.mask);
    cmp_val(32'(PSLVERR_O), 32'(n.err));
  endtask : cmp_rd
  // output watcher: a read answer is taken at the ready edge
  always @(posedge mclk)
  begin
    if (psel && penable && !pwrite && PREADY_O === 1'b1)
      cmp_rd();
  end
  // apb transfer: setup, access, hold until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge mclk);
      if (PREADY_O === 1'b1)
        break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16)
    begin
      errors++;
      print_verdict();
    end
  endtask : apb
  // register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // register read with its expectation noted first
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic e);
    notes.push_back('{d, m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // bounded wait for a rising one-second edge
  task automatic wait_rise();
    int   i;
    logic prev;
    prev = ONE_SEC_O;
    for (i = 0; i < LIMIT; i++)
    begin
      @(posedge mclk);
      if (ONE_SEC_O === 1'b1 && prev === 1'b0)
        break;
      prev = ONE_SEC_O;
    end
    if (i == LIMIT)
    begin
      errors++;
      print_verdict();
    end
  endtask : wait_rise
  // time word from its fields
  function automatic logic [31:0] tm(input int s, input int m, input int h);
    return 32'((s << rtc_trim_pkg::F_SEC) | (m << rtc_trim_pkg::F_MIN) |
               (h << rtc_trim_pkg::F_HR));
  endfunction : tm
  // date word from its fields
  function automatic logic [31:0] dt(input int d, input int mu, input int mt, input int w,
                                     input int y);
    return 32'((d << rtc_trim_pkg::F_DAY) | (mu << rtc_trim_pkg::F_MOU) |
               (mt << rtc_trim_pkg::F_MOT) | (w << rtc_trim_pkg::F_WDY) |
               (y << rtc_trim_pkg::F_YR));
  endfunction : dt
  // load counters while stopped, alarm on at 00:00, run, wait one count-up
  task automatic run_case(input logic [31:0] t, input logic [31:0] d, input logic h24);
    wr(rtc_trim_pkg::OFF_CTRL, {29'h0, 1'b1, h24, 1'b0});
    wr(rtc_trim_pkg::OFF_TIME, t);
    wr(rtc_trim_pkg::OFF_DATE, d);
    wr(rtc_trim_pkg::OFF_CTRL, {29'h0, 1'b1, h24, 1'b1});
    wait_rise();
    repeat (4) @(posedge mclk);
  endtask : run_case
  // trim write just after a tick, then two seconds measured
  task automatic trim_case(input logic [6:0] tv, input int tr);
    int t0;
    wait_rise();
    t0 = cyc;
    wr(rtc_trim_pkg::OFF_CTRL, 32'h0000_0003 | (32'(tv) << rtc_trim_pkg::CTL_TRIM));
    wait_rise();
    wait_rise();
    cmp_val(32'(cyc - t0), 32'((2 * TICKS - tr) * OSC));
  endtask : trim_case
  // main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    // reset values and an unmapped place
    rd(rtc_trim_pkg::OFF_CTRL, rtc_trim_pkg::CTRL_RST, 32'hFFFF_FFFF, 1'b0);
    rd(rtc_trim_pkg::OFF_TIME, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(rtc_trim_pkg::OFF_STAT, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(rtc_trim_pkg::OFF_MASK, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(rtc_trim_pkg::OFF_ALARM, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(8'h18, 32'h0, 32'hFFFF_FFFF, 1'b1);
    // random mask pattern read back
    rnd = $random(seed);
    wr(rtc_trim_pkg::OFF_MASK, rnd);
    rd(rtc_trim_pkg::OFF_MASK, rnd, 32'h0000_0003, 1'b0);
    wr(rtc_trim_pkg::OFF_MASK, 32'h0);
    // 24h hour out of range clears, no carry into date
    run_case(tm(59, 59, 30), dt(1, 1, 0, 0, 0), 1'b1);
    rd(rtc_trim_pkg::OFF_TIME, 32'h0, 32'hFFFF_FFFF, 1'b0);
    rd(rtc_trim_pkg::OFF_DATE, dt(1, 1, 0, 0, 0), 32'hFFFF_FFFF, 1'b0);
    // second and alarm events, interrupt raised, masked and cleared
    rd(rtc_trim_pkg::OFF_STAT, 32'h3, 32'h3, 1'b0);
    wr(rtc_trim_pkg::OFF_MASK, 32'h1);
    repeat (3) @(posedge mclk);
    cmp_val(32'(IRQ_O), 32'h1);
    wr(rtc_trim_pkg::OFF_STAT, 32'h1);
    repeat (3) @(posedge mclk);
    cmp_val(32'(IRQ_O), 32'h0);
    rd(rtc_trim_pkg::OFF_STAT, 32'h0, 32'h1, 1'b0);
    wr(rtc_trim_pkg::OFF_MASK, 32'h0);
    // weekday clears and month loads 1, year kept without its count-up
    run_case(tm(59, 59, 23), dt(31, 5, 1, 7, 100), 1'b1);
    rd(rtc_trim_pkg::OFF_DATE, dt(1, 1, 0, 0, 100), 32'hFFFF_FFFF, 1'b0);
    // day beyond month length loads 1, month kept
    run_case(tm(59, 59, 23), dt(31, 4, 0, 0, 1), 1'b1);
    rd(rtc_trim_pkg::OFF_DATE, dt(1, 4, 0, 0, 1), 32'h0000_1FFF, 1'b0);
    // year out of range clears at its count-up
    run_case(tm(59, 59, 23), dt(31, 2, 1, 0, 120), 1'b1);
    rd(rtc_trim_pkg::OFF_DATE, dt(1, 1, 0, 1, 0), 32'hFFFF_FFFF, 1'b0);
    // 12h hour out of range loads 1
    run_case(tm(59, 59, 13), dt(1, 1, 0, 0, 0), 1'b0);
    rd(rtc_trim_pkg::OFF_TIME, tm(0, 0, 1), 32'h001F_3F3F, 1'b0);
    // signed trim, one shortened then one lengthened interval
    wr(rtc_trim_pkg::OFF_CTRL, 32'h0000_0003);
    // trim values as software would pick them from a ppm correction
    trim_case(7'h02, 2);
    trim_case(7'h7E, -2);
    rd(rtc_trim_pkg::OFF_CTRL, 32'h0000_7E03, 32'h0000_7F07, 1'b0);
    repeat (4) @(posedge mclk);
    print_verdict();
  end
endmodule : rtc_range_fix_and_trim_test
